// ===== rtl/midi_host_io_port_pkg.sv
/*
 * Package for the host parallel I/O port: widths, decode defaults and the
 * packed carriers that move host cycle information and port state around.
 * Assumes a single 10 MHz clock domain; nothing here holds logic.
 */
package midi_host_io_port_pkg;

   // ------------------------------------------------------------------
   // Widths and defaults
   // ------------------------------------------------------------------
   localparam int          HOST_ADDR_W      = 10;
   localparam int          HOST_DATA_W      = 8;
   localparam int          PORT_ADDR_SPAN_W = 1;
   // Two-register port; the default base is arbitrary and is set per board.
   localparam logic [9:0]  PORT_BASE_DEF    = 10'h300;
   localparam logic [7:0]  DATA_RESET       = 8'h00;
   localparam logic        IRQ_RESET        = 1'b0;
   localparam logic        BUF_EN_N_RESET   = 1'b1;
   localparam logic        STROBE_IDLE      = 1'b1;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [HOST_ADDR_W-1:0] addr;
      logic                   addr_enable_n;
      logic                   select_n;
      logic                   rd_n;
      logic                   wr_n;
      logic [HOST_DATA_W-1:0] data;
   } host_cycle_s;

   typedef struct packed {
      logic                   wr_n_q;
      logic                   sel_q;
      logic [PORT_ADDR_SPAN_W-1:0] reg_q;
      logic [HOST_DATA_W-1:0] data_q;
      logic [HOST_DATA_W-1:0] rd_data;
      logic                   rd_oe;
      logic                   buf_en_n;
      logic                   irq;
      logic                   wr_pulse;
      logic [PORT_ADDR_SPAN_W-1:0] wr_reg;
      logic [HOST_DATA_W-1:0] wr_data;
      logic                   rd_pulse;
      logic [PORT_ADDR_SPAN_W-1:0] rd_reg;
      logic                   rd_n_q;
      logic                   strap;
      logic                   strap_valid;
      logic                   host_reset;
   } port_state_s;

endpackage : midi_host_io_port_pkg

// ===== rtl/midi_host_io_port.sv
/*
 * Host parallel I/O port of the MIDI interface emulation: address decode,
 * external select, strobes, data bus drive, buffer enable, host reset
 * polarity and interrupt. Assumes the host pins are synchronous to mclk_i
 * and that the register core behind the port answers reads combinationally.
 * Every output is registered, so each answer lags its cause by one clock.
 */
`timescale 1ns/10ps
module midi_host_io_port
   import midi_host_io_port_pkg::*;
#(
   parameter logic [HOST_ADDR_W-1:0] PORT_BASE = PORT_BASE_DEF
)
(
   input  wire logic                         mclk_i,                    // 10 MHz clock
   input  wire logic                         reset_n_i,                 // async reset, low
   input  wire logic [HOST_ADDR_W-1:0]       host_addr_in_i,            // host address
   input  wire logic                         host_addr_enable_n_i,      // address enable, low
   input  wire logic                         ext_select_n_i,            // external select, low
   input  wire logic                         host_io_read_n_i,          // read enable, low
   input  wire logic                         host_io_write_n_i,         // write strobe, low
   input  wire logic [HOST_DATA_W-1:0]       host_data_bus_i,           // data bus in
   output logic      [HOST_DATA_W-1:0]       host_data_bus_o,           // data bus out
   output logic                              host_data_bus_oe_o,        // data bus drive, high
   output logic                              data_buffer_enable_n_o,    // buffer enable, low
   input  wire logic                         host_reset_in_i,           // host reset pin
   input  wire logic                         host_reset_polarity_strap_i, // reset polarity strap
   output logic                              host_reset_o,              // host reset, high
   input  wire logic                         port_irq_req_i,            // core irq request
   output logic                              host_irq_out_o,            // host irq, high
   input  wire logic [HOST_DATA_W-1:0]       core_rd_data_i,            // core read data
   output logic                              core_wr_o,                 // write pulse
   output logic      [PORT_ADDR_SPAN_W-1:0]  core_wr_reg_o,             // written register
   output logic      [HOST_DATA_W-1:0]       core_wr_data_o,            // written data
   output logic                              core_rd_o,                 // read start pulse
   output logic      [PORT_ADDR_SPAN_W-1:0]  core_rd_reg_o              // read register
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (PORT_BASE[PORT_ADDR_SPAN_W-1:0] != '0)
   begin : g_base_check
      $error("PORT_BASE must be aligned to the port span");
   end

   if (PORT_ADDR_SPAN_W < 1 || PORT_ADDR_SPAN_W >= HOST_ADDR_W)
   begin : g_span_check
      $error("Port span must leave address bits to decode");
   end

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   host_cycle_s cyc;
   port_state_s st;
   port_state_s next_st;
   logic        addr_hit;
   logic        selected;
   logic        host_reset_act;
   logic        strap_now;
   logic        rd_active;
   logic        access_active;

   assign cyc = '{addr:          host_addr_in_i,
                  addr_enable_n: host_addr_enable_n_i,
                  select_n:      ext_select_n_i,
                  rd_n:          host_io_read_n_i,
                  wr_n:          host_io_write_n_i,
                  data:          host_data_bus_i};

   // Only the low ten address bits take part; upper bits never reach us.
   assign addr_hit = (cyc.addr[HOST_ADDR_W-1:PORT_ADDR_SPAN_W] ==
                      PORT_BASE[HOST_ADDR_W-1:PORT_ADDR_SPAN_W]);

   // The external select stands in for the address match only, so it works
   // with the address pins grounded. A high address enable marks a cycle
   // meant for someone else and blocks both ways of selection.
   assign selected = !cyc.addr_enable_n
                     && (addr_hit || !cyc.select_n);

   // ------------------------------------------------------------------
   // Access qualifiers
   // ------------------------------------------------------------------
   assign rd_active     = selected && !cyc.rd_n;
   assign access_active = selected && !(cyc.rd_n && cyc.wr_n);

   // ------------------------------------------------------------------
   // Host reset polarity
   // ------------------------------------------------------------------
   // Polarity follows the live strap until it has been caught after reset,
   // so a host reset that is already asserted at power up is not missed.
   assign strap_now      = st.strap_valid ? st.strap : host_reset_polarity_strap_i;
   assign host_reset_act = strap_now ? host_reset_in_i : !host_reset_in_i;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      next_st          = st;

      // --------------------------------------------------------------
      // Strobe history and strap capture
      // --------------------------------------------------------------
      next_st.wr_n_q   = cyc.wr_n;
      next_st.rd_n_q   = cyc.rd_n;
      next_st.wr_pulse = 1'b0;
      next_st.rd_pulse = 1'b0;
      next_st.strap_valid = 1'b1;
      if (!st.strap_valid)
      begin
         next_st.strap = host_reset_polarity_strap_i;
      end

      // --------------------------------------------------------------
      // Write capture
      // --------------------------------------------------------------
      // Selection and data are sampled while the strobe is low, so that a
      // select which drops together with the strobe still counts.
      if (!cyc.wr_n)
      begin
         next_st.sel_q  = selected;
         next_st.reg_q  = cyc.addr[PORT_ADDR_SPAN_W-1:0];
         next_st.data_q = cyc.data;
      end
      // The core sees one pulse per host write, one cycle after the strobe
      // has been seen high again, however long the strobe was held low.
      if (cyc.wr_n && !st.wr_n_q && st.sel_q)
      begin
         next_st.wr_pulse = 1'b1;
         next_st.wr_reg   = st.reg_q;
         next_st.wr_data  = st.data_q;
         next_st.sel_q    = 1'b0;
      end

      // --------------------------------------------------------------
      // Read start
      // --------------------------------------------------------------
      // Only the first low cycle counts, so a core that pops a queue on a
      // read loses one entry per host read, not one per cycle.
      if (!cyc.rd_n && st.rd_n_q && rd_active)
      begin
         next_st.rd_pulse = 1'b1;
         next_st.rd_reg   = cyc.addr[PORT_ADDR_SPAN_W-1:0];
      end

      // --------------------------------------------------------------
      // Bus drive, buffer enable and interrupt
      // --------------------------------------------------------------
      next_st.rd_oe      = rd_active;
      next_st.rd_data    = DATA_RESET;
      if (rd_active)
      begin
         next_st.rd_data = core_rd_data_i;
      end
      next_st.buf_en_n   = !access_active;
      next_st.irq        = port_irq_req_i;
      next_st.host_reset = host_reset_act;

      // --------------------------------------------------------------
      // Host reset
      // --------------------------------------------------------------
      // A host reset drops any access in flight. The caught strap is kept,
      // so the polarity cannot turn while a host reset is running.
      if (host_reset_act)
      begin
         next_st.sel_q    = 1'b0;
         next_st.rd_data  = DATA_RESET;
         next_st.wr_pulse = 1'b0;
         next_st.rd_pulse = 1'b0;
         next_st.rd_oe    = 1'b0;
         next_st.buf_en_n = BUF_EN_N_RESET;
         next_st.irq      = IRQ_RESET;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // The strobe history resets to the idle level, so that the release of
   // reset can never look like the end of a write; a read strobe held low across it counts as a read start.
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st <= '{wr_n_q: STROBE_IDLE, rd_n_q: STROBE_IDLE, buf_en_n: BUF_EN_N_RESET,
                 irq: IRQ_RESET, default: '0};
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign host_data_bus_o        = st.rd_data;
   assign host_data_bus_oe_o     = st.rd_oe;
   assign data_buffer_enable_n_o = st.buf_en_n;
   assign host_irq_out_o         = st.irq;
   assign host_reset_o           = st.host_reset;
   assign core_wr_o              = st.wr_pulse;
   assign core_wr_reg_o          = st.wr_reg;
   assign core_wr_data_o         = st.wr_data;
   assign core_rd_o              = st.rd_pulse;
   assign core_rd_reg_o          = st.rd_reg;

endmodule : midi_host_io_port

// ===== sim/midi_host_io_port_checker.sv
/* Timing checks on the host port, attached by bind.
   Assumes the strap is held steady across each reset. */
`timescale 1ns/10ps
module midi_host_io_port_checker
   import midi_host_io_port_pkg::*;
#(
   parameter logic [HOST_ADDR_W-1:0] PORT_BASE = PORT_BASE_DEF
)
(
   input wire logic                   mclk_i,                      // clock
   input wire logic                   reset_n_i,                   // reset
   input wire logic [HOST_ADDR_W-1:0] host_addr_in_i,              // address
   input wire logic                   host_addr_enable_n_i,        // enable
   input wire logic                   ext_select_n_i,              // select
   input wire logic                   host_io_read_n_i,            // read
   input wire logic                   host_io_write_n_i,           // write
   input wire logic [HOST_DATA_W-1:0] host_data_bus_i,             // bus in
   input wire logic [HOST_DATA_W-1:0] host_data_bus_o,             // bus out
   input wire logic                   host_data_bus_oe_o,          // drive
   input wire logic                   data_buffer_enable_n_o,      // buffer
   input wire logic                   host_reset_in_i,             // reset pin
   input wire logic                   host_reset_polarity_strap_i, // strap
   input wire logic                   host_reset_o,                // reset out
   input wire logic [HOST_DATA_W-1:0] core_rd_data_i,              // core data
   input wire logic                   core_wr_o,                   // write pulse
   input wire logic [0:0]             core_wr_reg_o,               // write index
   input wire logic [HOST_DATA_W-1:0] core_wr_data_o,              // write data
   input wire logic                   core_rd_o,                   // read pulse
   input wire logic [0:0]             core_rd_reg_o,               // read index
   input wire logic                   port_irq_req_i,              // irq request
   input wire logic                   host_irq_out_o               // irq out
);
   logic       sel;
   logic       rst_act;
   logic       ok;
   logic [1:0] up;
   assign sel = !host_addr_enable_n_i && (host_addr_in_i[9:1] == PORT_BASE[9:1] || !ext_select_n_i);
   assign rst_act = host_reset_in_i == host_reset_polarity_strap_i;
   // The strap is only trusted two edges after release, once it has been captured.
   always_ff @(posedge mclk_i or negedge reset_n_i)
      if (!reset_n_i) up <= 2'h0;
      else up <= {up[0], 1'b1};
   assign ok = up[1] && !rst_act && !host_reset_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   chk_oe_cause: assert property (host_data_bus_oe_o |-> $past(sel && !host_io_read_n_i))
      else $error("bus driven outside a selected read");
   chk_read_drive: assert property (ok && sel && !host_io_read_n_i |=>
      host_data_bus_oe_o && host_data_bus_o == $past(core_rd_data_i)) else $error("read not driven");
   chk_buf_low: assert property (ok && sel && !(host_io_read_n_i && host_io_write_n_i)
      |=> !data_buffer_enable_n_o) else $error("buffer enable missing");
   chk_buf_cause: assert property (!data_buffer_enable_n_o |->
      $past(sel && !(host_io_read_n_i && host_io_write_n_i))) else $error("buffer enable stray");
   chk_wr_cause: assert property (core_wr_o |-> $past(host_io_write_n_i) &&
      $past(!host_io_write_n_i && sel, 2)) else $error("stray write pulse");
   chk_wr_data: assert property (core_wr_o |-> core_wr_data_o == $past(host_data_bus_i, 2) &&
      core_wr_reg_o == $past(host_addr_in_i[0], 2)) else $error("write data wrong");
   chk_wr_taken: assert property (ok && sel && !host_io_write_n_i ##1 host_io_write_n_i && !rst_act
      |=> core_wr_o) else $error("write lost");
   chk_rst_pol: assert property (up[1] |-> host_reset_o == $past(rst_act))
      else $error("reset polarity wrong");
   chk_irq_follow: assert property (ok |=> host_irq_out_o == $past(port_irq_req_i))
      else $error("irq does not follow request");
   chk_rd_start: assert property (core_rd_o |-> $past(sel && !host_io_read_n_i) &&
      core_rd_reg_o == $past(host_addr_in_i[0])) else $error("stray or misplaced read pulse");
endmodule : midi_host_io_port_checker

// ===== sim/host_bus_model.sv
/* Host bus model: drives address, enable, select, strobes and write data.
   Assumes cyc is called at a falling edge of clk_i. */
`timescale 1ns/10ps
module host_bus_model
   import midi_host_io_port_pkg::*;
(
   input  wire logic                   clk_i,   // clock
   output logic      [HOST_ADDR_W-1:0] addr_o,  // address
   output logic                        aen_n_o, // enable
   output logic                        cs_n_o,  // select
   output logic                        rd_n_o,  // read
   output logic                        wr_n_o,  // write
   output logic      [HOST_DATA_W-1:0] data_o   // data
);
   initial {addr_o, aen_n_o, cs_n_o, rd_n_o, wr_n_o, data_o} = {10'h000, 4'hF, 8'h00};
   // Strobe low one cycle, high one cycle; released data shows its inverse.
   task automatic cyc(input logic [9:0] a, input logic e, s, r, input logic [7:0] d);
      {addr_o, aen_n_o, cs_n_o, data_o} = {a, e, s, d};
      if (r) rd_n_o = 1'b0;
      else wr_n_o = 1'b0;
      @(negedge clk_i);
      {rd_n_o, wr_n_o} = 2'h3;
      @(negedge clk_i);
      {aen_n_o, cs_n_o, data_o} = {2'h3, ~d};
   endtask : cyc
endmodule : host_bus_model

// ===== sim/tb.sv
/* Bench for the host port: host model, core stand-in, scenarios, verdict.
   Assumes the checker and host model are compiled before it. */
`timescale 1ns/10ps
bind midi_host_io_port midi_host_io_port_checker #(.PORT_BASE(PORT_BASE)) u_chk (.*);
module tb;
   import midi_host_io_port_pkg::*;
   localparam logic [9:0] B = PORT_BASE_DEF;
   logic mclk_i, reset_n_i, strap, hrin, irq, ae, cs, rd, wr, oe, ben, hro, hio, cw, cr;
   logic [0:0] wreg, rreg, rcap;
   logic [9:0] a;
   logic [7:0] hwd, qd, wdo, cd, ocap;
   logic [8:0] wcap;
   int nw, nr, noe, nbuf, checked = 0, n_mismatch = 0;
   assign cd = 8'hA5 ^ {7'h00, a[0]};
   host_bus_model hb (.clk_i(mclk_i), .addr_o(a), .aen_n_o(ae), .cs_n_o(cs), .rd_n_o(rd), .wr_n_o(wr), .data_o(hwd));
   midi_host_io_port dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .host_addr_in_i(a), .host_addr_enable_n_i(ae),
      .ext_select_n_i(cs), .host_io_read_n_i(rd), .host_io_write_n_i(wr), .host_data_bus_i(hwd),
      .host_data_bus_o(qd), .host_data_bus_oe_o(oe), .data_buffer_enable_n_o(ben), .host_reset_in_i(hrin),
      .host_reset_polarity_strap_i(strap), .host_reset_o(hro), .port_irq_req_i(irq), .host_irq_out_o(hio),
      .core_rd_data_i(cd), .core_wr_o(cw), .core_wr_reg_o(wreg), .core_wr_data_o(wdo), .core_rd_o(cr),
      .core_rd_reg_o(rreg));
   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // Sampled just after the edge so registered outputs have settled.
   always @(posedge mclk_i)
   begin
      #1;
      nw += (cw === 1'b1);
      nr += (cr === 1'b1);
      noe += (oe === 1'b1);
      nbuf += (ben === 1'b0);
      if (cw === 1'b1) wcap = {wreg, wdo};
      if (oe === 1'b1) ocap = qd;
      if (cr === 1'b1) rcap = rreg;
   end
   task automatic chk(input logic good, input string m);
      checked++;
      if (good !== 1'b1)
      begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic acc(input logic [9:0] ad, input logic e, s, r, input logic [7:0] d, input logic hit);
      {nw, nr, noe, nbuf} = {32'd0, 32'd0, 32'd0, 32'd0};
      {wcap, ocap, rcap} = 'x;
      hb.cyc(ad, e, s, r, d);
      repeat (2) @(negedge mclk_i);
      chk((nw == 1) === (hit && !r) && (nr == 1) === (hit && r) && (noe > 0) === (hit && r)
         && (nbuf > 0) === hit, "access outcome");
      if (hit && r) chk(rcap === ad[0], "read index");
      if (hit && !r) chk(wcap === {ad[0], d}, "write data");
      if (hit && r) chk(ocap === (8'hA5 ^ {7'h00, ad[0]}), "read data");
   endtask : acc
   task automatic t_write;
      acc(B, 1'b0, 1'b1, 1'b0, 8'h3C, 1'b1);
      acc(B | 10'h001, 1'b0, 1'b1, 1'b0, 8'hC3, 1'b1);
   endtask : t_write
   task automatic t_refuse;
      acc(B ^ 10'h200, 1'b0, 1'b1, 1'b0, 8'h5A, 1'b0);
      acc(B ^ 10'h002, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0);
      acc(B, 1'b1, 1'b1, 1'b0, 8'h77, 1'b0);
      acc(B, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0);
      acc(10'h000, 1'b1, 1'b0, 1'b0, 8'h66, 1'b0);
   endtask : t_refuse
   task automatic t_select;
      acc(10'h000, 1'b0, 1'b0, 1'b0, 8'h81, 1'b1);
      acc(10'h000, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1);
   endtask : t_select
   task automatic t_read;
      acc(B | 10'h001, 1'b0, 1'b1, 1'b1, 8'h00, 1'b1);
      acc(B, 1'b0, 1'b1, 1'b1, 8'h00, 1'b1);
   endtask : t_read
   task automatic t_irq;
      irq = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk(hio === 1'b1, "irq not raised");
      irq = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk(hio === 1'b0, "irq stuck");
   endtask : t_irq
   task automatic t_host_reset_in;
      hrin = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk(hro === 1'b1, "high reset missed");
      acc(B, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0);
      reset_n_i = 1'b0;
      strap = 1'b0;
      @(negedge mclk_i);
      reset_n_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk(hro === 1'b0, "low strap inverted");
      hrin = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk(hro === 1'b1, "low reset missed");
      hrin = 1'b1;
      acc(B, 1'b0, 1'b1, 1'b0, 8'hE7, 1'b1);
   endtask : t_host_reset_in
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      {reset_n_i, strap, hrin, irq} = 4'h4;
      repeat (8) @(negedge mclk_i);
      reset_n_i = 1'b1;
      @(negedge mclk_i);
      t_write;
      t_refuse;
      t_select;
      t_read;
      t_irq;
      t_host_reset_in;
      complete_run;
   end
   // The scenarios need about 72 cycles; nearly thirty times that means a hang.
   initial
   begin
      #200000;
      n_mismatch++;
      complete_run;
   end
endmodule : tb
